// >>> hdl/dgea_pkg.sv
// Constants shared by the global enable and channel address block.
// Assumes a 32-bit register port with 12-bit byte addresses.
package dgea_pkg;

	localparam int          DGEA_ADDR_W        = 12;
	localparam int          DGEA_DATA_W        = 32;
	localparam int          DGEA_CHANNELS      = 2;

	// Register map, byte addresses
	localparam logic [11:0] DGEA_GLOBAL_OFS    = 12'h030;
	localparam logic [11:0] DGEA_CH_BASE       = 12'h100;
	localparam logic [11:0] DGEA_CH_STRIDE     = 12'h020;
	localparam logic [11:0] DGEA_SRC_OFS       = 12'h000;
	localparam logic [11:0] DGEA_DST_OFS       = 12'h004;

	// Field positions
	localparam int          DGEA_GLOBAL_EN_BIT = 0;
	localparam int          DGEA_SRC_INC_BIT   = 26;
	localparam int          DGEA_DST_INC_BIT   = 27;
	localparam int          DGEA_SRC_WIDTH_LSB = 18;
	localparam int          DGEA_DST_WIDTH_LSB = 21;

	// Reset values
	localparam logic        DGEA_GLOBAL_EN_RST = 1'b0;
	localparam logic [31:0] DGEA_ADDR_RST      = 32'h00000000;

	// Transfer width codes
	typedef logic [2:0] dgea_width_t;
	localparam dgea_width_t DGEA_W_BYTE        = 3'h0;
	localparam dgea_width_t DGEA_W_HALF        = 3'h1;
	localparam dgea_width_t DGEA_W_WORD        = 3'h2;

	// Address step for a width code; unknown codes step as bytes
	function automatic logic [31:0] dgea_step(input dgea_width_t w);
		case (w)
			DGEA_W_HALF: dgea_step = 32'h00000002;
			DGEA_W_WORD: dgea_step = 32'h00000004;
			default:     dgea_step = 32'h00000001;
		endcase
	endfunction : dgea_step

endpackage : dgea_pkg

// >>> hdl/dgea_buf_if.sv
// Carrier between the address block and its two-entry buffer.
// Assumes both ends run on the same clock.
interface dgea_buf_if #(parameter int W = 8);
	logic         push_valid;
	logic         push_ready;
	logic [W-1:0] push_data;
	logic         pop_valid;
	logic         pop_ready;
	logic [W-1:0] pop_data;

	modport fill  (output push_valid, output push_data, input push_ready,
	               input pop_valid, input pop_data, output pop_ready);
	modport store (input push_valid, input push_data, output push_ready,
	               output pop_valid, output pop_data, input pop_ready);
endinterface : dgea_buf_if

// >>> hdl/dgea_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and asynchronous active-low reset.
module dgea_buf #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic   clk,
	input  wire logic   reset_n,
	// Buffer ports
	dgea_buf_if.store   bif
);
	import dgea_pkg::*;

	// Refused at elaboration: an empty word has nothing to hold
	if (W < 1) begin : g_bad_w
		$error("dgea_buf: W must be at least 1");
	end

	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic              rp;
		logic              wp;
		logic [1:0]        cnt;
	} dgea_buf_s;

	dgea_buf_s q;
	dgea_buf_s d;
	logic      push;
	logic      pop;

	// Full at two, so a stalled reader never loses a word
	assign bif.push_ready = (q.cnt != 2'h2);
	assign bif.pop_valid  = (q.cnt != 2'h0);
	assign bif.pop_data   = q.mem[q.rp];

	always_comb begin
		d    = q;
		push = bif.push_valid & bif.push_ready;
		pop  = bif.pop_valid & bif.pop_ready;
		if (push) begin
			d.mem[q.wp] = bif.push_data;
			d.wp        = ~q.wp;
		end
		if (pop) begin
			d.rp = ~q.rp;
		end
		case ({push, pop})
			2'b10:   d.cnt = q.cnt + 2'h1;
			2'b01:   d.cnt = q.cnt - 2'h1;
			default: d.cnt = q.cnt;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule : dgea_buf

// >>> hdl/dgea_top.sv
// Global controller enable and per-channel source/destination addresses.
// Assumes channel enables and control words come from logic on clk.
module dgea_top #(
	parameter int N = dgea_pkg::DGEA_CHANNELS
) (
	// Clock and reset
	input  wire logic                                clk,
	input  wire logic                                reset_n,
	// Register port
	input  wire logic [dgea_pkg::DGEA_ADDR_W-1:0]    reg_addr,
	input  wire logic [dgea_pkg::DGEA_DATA_W-1:0]    reg_wdata,
	input  wire logic                                reg_wr,
	input  wire logic                                reg_rd,
	output logic      [dgea_pkg::DGEA_DATA_W-1:0]    reg_rdata,
	// Channel controls from the rest of the controller
	input  wire logic [N-1:0]                        ch_enable,
	input  wire logic [N-1:0][31:0]                  ch_control,
	// Global state
	output logic                                     dma_operate,
	// Beat requests
	input  wire logic                                beat_valid,
	output logic                                     beat_ready,
	input  wire logic [((N > 1) ? $clog2(N) : 1)-1:0] beat_channel,
	// Addresses for each beat
	output logic                                     xfer_valid,
	input  wire logic                                xfer_ready,
	output logic      [((N > 1) ? $clog2(N) : 1)-1:0] xfer_channel,
	output logic      [31:0]                         xfer_src,
	output logic      [31:0]                         xfer_dst
);
	import dgea_pkg::*;

	localparam int CH_W  = (N > 1) ? $clog2(N) : 1;
	localparam int BUF_W = CH_W + 64;

	// Refused at elaboration: the channel select is at most six bits wide
	if (N < 1 || N > 64) begin : g_bad_n
		$error("dgea_top: N must be 1 to 64");
	end

	typedef struct packed {
		logic                   glob_en;
		logic [N-1:0]           en_prev;
		logic [N-1:0][31:0]     prog_src;
		logic [N-1:0][31:0]     prog_dst;
		logic [N-1:0][31:0]     work_src;
		logic [N-1:0][31:0]     work_dst;
		logic [DGEA_DATA_W-1:0] rdata;
	} dgea_state_s;

	dgea_state_s q;
	dgea_state_s d;

	dgea_buf_if #(.W(BUF_W)) bif ();

	// Channel register decode
	function automatic logic [CH_W+1:0] dgea_decode(input logic [DGEA_ADDR_W-1:0] a);
		logic [CH_W+1:0] r;
		logic [11:0]     base;
		r = '0;
		for (int i = 0; i < N; i++) begin
			base = 12'(DGEA_CH_BASE + 12'(i) * DGEA_CH_STRIDE);
			if (a == 12'(base + DGEA_SRC_OFS)) begin
				r = {1'b1, 1'b0, CH_W'(i)};
			end
			if (a == 12'(base + DGEA_DST_OFS)) begin
				r = {1'b1, 1'b1, CH_W'(i)};
			end
		end
		dgea_decode = r;
	endfunction : dgea_decode

	logic [CH_W+1:0] dec;
	logic            hit;
	logic            hit_dst;
	logic [CH_W-1:0] hit_ch;
	logic            beat_ok;
	logic            take;

	assign dec     = dgea_decode(reg_addr);
	assign hit     = dec[CH_W+1];
	assign hit_dst = dec[CH_W];
	assign hit_ch  = dec[CH_W-1:0];

	// Beats only while operating and the channel is enabled
	assign beat_ok    = q.glob_en & (int'(beat_channel) < N) & ch_enable[beat_channel];
	assign beat_ready = beat_ok & bif.push_ready;
	assign take       = beat_valid & beat_ready;

	assign bif.push_valid = beat_valid & beat_ok;
	assign bif.pop_ready  = xfer_ready;
	assign xfer_valid     = bif.pop_valid;
	assign xfer_channel   = bif.pop_data[BUF_W-1 -: CH_W];
	assign xfer_src       = bif.pop_data[63:32];
	assign xfer_dst       = bif.pop_data[31:0];
	assign dma_operate    = q.glob_en;
	assign reg_rdata      = q.rdata;

	always_comb begin
		d       = q;
		d.rdata = '0;
		bif.push_data = '0;

		for (int i = 0; i < N; i++) begin
			d.en_prev[i] = ch_enable[i];
			if (ch_enable[i] && !q.en_prev[i]) begin
				d.work_src[i] = q.prog_src[i];
				d.work_dst[i] = q.prog_dst[i];
			end
		end

		if (take) begin
			bif.push_data = {beat_channel, d.work_src[beat_channel], d.work_dst[beat_channel]};
			// Fixed addresses stay put when the increment bit is clear
			if (ch_control[beat_channel][DGEA_SRC_INC_BIT]) begin
				d.work_src[beat_channel] = d.work_src[beat_channel] + dgea_step(
					ch_control[beat_channel][DGEA_SRC_WIDTH_LSB +: 3]);
			end
			if (ch_control[beat_channel][DGEA_DST_INC_BIT]) begin
				d.work_dst[beat_channel] = d.work_dst[beat_channel] + dgea_step(
					ch_control[beat_channel][DGEA_DST_WIDTH_LSB +: 3]);
			end
		end

		// Alignment is left to software; addresses are stored as written
		if (reg_wr) begin
			if (reg_addr == DGEA_GLOBAL_OFS) begin
				d.glob_en = reg_wdata[DGEA_GLOBAL_EN_BIT];
			end else if (hit && q.glob_en) begin
				if (hit_dst) begin
					d.prog_dst[hit_ch] = reg_wdata;
				end else begin
					d.prog_src[hit_ch] = reg_wdata;
				end
			end
		end

		if (reg_rd) begin
			if (reg_addr == DGEA_GLOBAL_OFS) begin
				d.rdata[DGEA_GLOBAL_EN_BIT] = q.glob_en;
			end else if (hit && q.glob_en) begin
				// Live value while enabled, so reads are not stable then
				if (hit_dst) begin
					d.rdata = ch_enable[hit_ch] ? q.work_dst[hit_ch] : q.prog_dst[hit_ch];
				end else begin
					d.rdata = ch_enable[hit_ch] ? q.work_src[hit_ch] : q.prog_src[hit_ch];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q          <= '0;
			q.glob_en  <= DGEA_GLOBAL_EN_RST;
			q.prog_src <= {N{DGEA_ADDR_RST}};
			q.prog_dst <= {N{DGEA_ADDR_RST}};
			q.work_src <= {N{DGEA_ADDR_RST}};
			q.work_dst <= {N{DGEA_ADDR_RST}};
		end else begin
			q <= d;
		end
	end

	dgea_buf #(.W(BUF_W)) u_buf (
		.clk     (clk),
		.reset_n (reset_n),
		.bif     (bif)
	);

endmodule : dgea_top

// >>> test/dgea_top_asserts.sv
// Checker for the global enable and channel address block.
// Assumes binding to dgea_top; sees only its ports.
module dgea_top_asserts
	import dgea_pkg::*;
#(parameter int N = 2, parameter int CW = (N > 1) ? $clog2(N) : 1) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register port
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Channels and state
	input wire logic [N-1:0] ch_enable,
	input wire logic [N-1:0][31:0] ch_control,
	input wire logic dma_operate,
	// Beats
	input wire logic beat_valid,
	input wire logic beat_ready,
	input wire logic [CW-1:0] beat_channel,
	input wire logic xfer_valid,
	input wire logic xfer_ready,
	input wire logic [CW-1:0] xfer_channel,
	input wire logic [31:0] xfer_src,
	input wire logic [31:0] xfer_dst
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire g_wr = reg_wr && reg_addr == DGEA_GLOBAL_OFS;
	wire g_rd = reg_rd && reg_addr == DGEA_GLOBAL_OFS;
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("idle read data");
	AST_GLB_SET: assert property (g_wr |=> dma_operate == $past(reg_wdata[0])) else $error("enable set");
	AST_GLB_KEEP: assert property (!g_wr |=> $stable(dma_operate)) else $error("enable moved");
	AST_GLB_RD: assert property (g_rd |=> reg_rdata == {31'h0, $past(dma_operate)}) else $error("enable read");
	AST_OFF_RD: assert property (reg_rd && !dma_operate && !g_rd |=> reg_rdata == 32'h0) else $error("read off");
	AST_OFF_BEAT: assert property (!dma_operate |-> !beat_ready) else $error("beat while off");
	AST_CH_BEAT: assert property (beat_ready |-> ch_enable[beat_channel]) else $error("beat off chan");
	AST_TAKE: assert property (beat_valid && beat_ready && !xfer_valid |=> xfer_valid) else $error("no xfer");
	AST_HOLD: assert property (xfer_valid && !xfer_ready |=> xfer_valid && $stable({xfer_src, xfer_dst}))
		else $error("xfer moved");
endmodule : dgea_top_asserts

bind dgea_top dgea_top_asserts #(.N(N)) u_dgea_top_asserts (.*);

// >>> test/dgea_top_test.sv
// Random and corner testbench for the address block.
// Assumes two channels and xfer_ready mostly high.
module dgea_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import dgea_pkg::*;
	logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, beat_valid = 0, xfer_ready = 1, beat_channel = 0, c;
	logic [11:0] reg_addr = 0, a;
	logic [31:0] reg_wdata = 0, reg_rdata, xfer_src, xfer_dst, s, d, r;
	logic [2:0] w, wd;
	logic [1:0] ch_enable = 0;
	logic [1:0][31:0] ch_control = 0;
	logic dma_operate, beat_ready, xfer_valid, xfer_channel;
	int num_errors = 0, compares = 0, seed = 32'h54a91c99, i, k;
	dgea_top u_dgea_top (.*);
	initial forever #12.5 clk = ~clk;
	task print_verdict;
		if (num_errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : print_verdict
	task bad;
		num_errors++;
		print_verdict();
	endtask : bad
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task wr(input logic [11:0] x, input logic [31:0] v);
		reg_wr <= 1;
		reg_addr <= x;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 0;
		// Idle edge, so a following write never drives the strobe twice at once
		@(posedge clk);
	endtask : wr
	task rd(input logic [11:0] x, input logic [31:0] e);
		reg_rd <= 1;
		reg_addr <= x;
		@(posedge clk);
		reg_rd <= 0;
		#1 chk("reg_rdata", e, reg_rdata);
		@(posedge clk);
	endtask : rd
	// Leaves beat_valid high so back-to-back beats never double-drive it
	task beat(input logic ch);
		beat_valid <= 1;
		beat_channel <= ch;
		i = 0;
		@(negedge clk);
		while (beat_ready !== 1'b1) begin
			if (++i > 20) bad();
			@(negedge clk);
		end
		@(posedge clk);
	endtask : beat
	task xchk(input logic ch, input logic [31:0] es, input logic [31:0] ed);
		i = 0;
		@(negedge clk);
		while (xfer_valid !== 1'b1) begin
			if (++i > 20) bad();
			@(negedge clk);
		end
		chk("xfer_channel", {31'h0, ch}, {31'h0, xfer_channel});
		chk("xfer_src", es, xfer_src);
		chk("xfer_dst", ed, xfer_dst);
		@(posedge clk);
	endtask : xchk
	function automatic logic [31:0] stp(input logic [2:0] x);
		return (x == 3'h1) ? 32'h2 : (x == 3'h2) ? 32'h4 : 32'h1;
	endfunction : stp
	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1;
		@(posedge clk);
		rd(DGEA_GLOBAL_OFS, 32'h0);
		wr(DGEA_CH_BASE, 32'h5a5a5a5a);
		wr(DGEA_GLOBAL_OFS, 32'h3);
		rd(DGEA_GLOBAL_OFS, 32'h1);
		rd(DGEA_CH_BASE, 32'h0);
		for (k = 0; k < 9; k++) begin
			c = k[0];
			w = 3'(k % 3);
			wd = 3'((k + 1) % 3);
			r = $random(seed);
			s = $random(seed) & ~(stp(w) - 32'h1);
			d = $random(seed) & ~(stp(wd) - 32'h1);
			a = c ? DGEA_CH_BASE + DGEA_CH_STRIDE : DGEA_CH_BASE;
			ch_control[c] <= {4'h0, r[1], r[0], 2'h0, wd, w, 18'h0};
			wr(a + DGEA_SRC_OFS, s);
			wr(a + DGEA_DST_OFS, d);
			ch_enable[c] <= 1'b1;
			@(posedge clk);
			repeat (3) begin
				beat(c);
				beat_valid <= 0;
				xchk(c, s, d);
				s += r[0] ? stp(w) : 32'h0;
				d += r[1] ? stp(wd) : 32'h0;
			end
			rd(a + DGEA_SRC_OFS, s);
			ch_enable[c] <= 1'b0;
			@(posedge clk);
			wr(a + DGEA_DST_OFS, ~d);
			rd(a + DGEA_DST_OFS, ~d);
		end
		// Stall the receiver until the buffer refuses
		wr(DGEA_CH_BASE, 32'h100);
		wr(DGEA_CH_BASE + DGEA_DST_OFS, 32'h200);
		ch_control[0] <= {4'h0, 2'h3, 2'h0, 3'h2, 3'h2, 18'h0};
		ch_enable[0] <= 1'b1;
		xfer_ready <= 0;
		@(posedge clk);
		beat(1'b0);
		beat(1'b0);
		beat_valid <= 0;
		@(negedge clk);
		chk("beat_ready", 32'h0, {31'h0, beat_ready});
		@(posedge clk);
		xfer_ready <= 1;
		xchk(1'b0, 32'h100, 32'h200);
		xchk(1'b0, 32'h104, 32'h204);
		wr(DGEA_GLOBAL_OFS, 32'h0);
		rd(DGEA_CH_BASE, 32'h0);
		rd(12'hffc, 32'h0);
		// Mid-run reset with channel 0 still enabled
		reset_n <= 0;
		@(posedge clk);
		reset_n <= 1;
		@(posedge clk);
		@(negedge clk);
		chk("xfer_valid", 32'h0, {31'h0, xfer_valid});
		chk("dma_operate", 32'h0, {31'h0, dma_operate});
		@(posedge clk);
		rd(DGEA_GLOBAL_OFS, 32'h0);
		wr(DGEA_GLOBAL_OFS, 32'h1);
		rd(DGEA_CH_BASE + DGEA_DST_OFS, 32'h0);
		print_verdict();
	end
endmodule : dgea_top_test
